//--- hdl/dpa_cfg.svh
// Timing counts and field positions for the two-port memory host controller
`ifndef DPA_CFG_SVH
`define DPA_CFG_SVH
`define DPA_CLK_NS 50
`define DPA_ADDR_W 15
`define DPA_DATA_W 16
`define DPA_TOKEN_W 3
// Pin timing in ns, as printed for the slowest grade
`define DPA_ACCESS_NS 25
`define DPA_WRITE_PULSE_NS 22
`define DPA_TOKEN_UPDATE_PULSE_NS 12
`define DPA_TOKEN_WRITE_READ_GAP_NS 5
`define DPA_COLLISION_RELEASE_DATA_DELAY_NS 25
// Cycle counts: least times round up
`define DPA_CYC(ns) (((ns) + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
`define DPA_ACCESS_CYC (`DPA_CYC(`DPA_ACCESS_NS) + 1)
`define DPA_WRITE_PULSE_CYC (`DPA_CYC(`DPA_WRITE_PULSE_NS) + 1)
`define DPA_TOKEN_UPDATE_PULSE_CYC `DPA_CYC(`DPA_TOKEN_UPDATE_PULSE_NS)
`define DPA_TOKEN_WRITE_READ_GAP_CYC `DPA_CYC(`DPA_TOKEN_WRITE_READ_GAP_NS)
`define DPA_RELEASE_CYC `DPA_CYC(`DPA_COLLISION_RELEASE_DATA_DELAY_NS)
// Mailbox locations
`define DPA_MAILBOX_PEER 15'h7FFF
`define DPA_MAILBOX_OWN 15'h7FFE
`endif

//--- hdl/dpa_host.sv
// Host-side controller driving one port of the two-port memory
`timescale 1ns/1ps
`default_nettype none
`include "dpa_cfg.svh"
module dpa_host
  import dpa_pkg::*;
(
  input wire logic mclk_i, // 20 MHz clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic req_i, // Start a transfer, level while idle
  input wire logic [1:0] op_i, // dpa_op_e code
  input wire logic [14:0] addr_i, // Word or token address
  input wire logic [15:0] wdata_i, // Write data
  input wire logic [1:0] lanes_i, // Bit1 upper lane, bit0 lower lane
  output logic ack_o, // One-cycle done pulse
  output logic [15:0] rdata_o, // Read data, held
  output logic mailbox_pending_o, // Mailbox flag seen low
  output logic [14:0] addr_o, // Address pins
  output logic select_n_o, // Port select pin
  output logic write_n_o, // Write strobe pin
  output logic gate_n_o, // Output gate pin
  output logic high_lane_select_n_o, // Upper lane select
  output logic low_lane_select_n_o, // Lower lane select
  output logic token_space_select_n_o, // Token space select
  input wire logic [15:0] data_i, // Data pins in
  output logic [15:0] data_o, // Data pins out
  output logic data_oe_o, // High while host drives data
  input wire logic collision_n_i, // Collision flag pin
  input wire logic mailbox_n_i // Mailbox flag pin
);
  dpa_sync_if sy ();
  dpa_sync u_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .data_pin_i(data_i),
    .collision_n_i(collision_n_i),
    .mailbox_n_i(mailbox_n_i),
    .sy(sy)
  );
  dpa_state_e state;
  dpa_state_e next_state;
  dpa_op_e op;
  dpa_op_e next_op;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [14:0] addr;
  logic [14:0] next_addr;
  logic [15:0] wdata;
  logic [15:0] next_wdata;
  logic [1:0] lanes;
  logic [1:0] next_lanes;
  logic sel_n, next_sel_n, wr_n, next_wr_n, gate_n, next_gate_n;
  logic hi_n, next_hi_n, lo_n, next_lo_n, tok_n, next_tok_n, oe, next_oe;
  logic ack, next_ack, mbox, next_mbox;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic is_token, is_write;
  assign is_token = (op == DPA_OP_TOKEN_WRITE) || (op == DPA_OP_TOKEN_READ);
  assign is_write = (op == DPA_OP_WRITE) || (op == DPA_OP_TOKEN_WRITE);
  // ************************************************************
  // Cycle sequencer
  // ************************************************************
  // Address moves only in idle with all strobes high, so no write spans it
  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_addr = addr;
    next_wdata = wdata;
    next_lanes = lanes;
    next_sel_n = sel_n;
    next_wr_n = wr_n;
    next_gate_n = gate_n;
    next_hi_n = hi_n;
    next_lo_n = lo_n;
    next_tok_n = tok_n;
    next_oe = oe;
    next_ack = 1'b0;
    next_rdata = rdata;
    next_mbox = !sy.mailbox_n;
    unique case (state)
      DPA_IDLE: begin
        next_wr_n = 1'b1;
        next_gate_n = 1'b1;
        next_oe = 1'b0;
        if (req_i) begin
          next_op = dpa_op_e'(op_i);
          next_addr = addr_i;
          next_wdata = wdata_i;
          next_lanes = lanes_i;
          next_cnt = 4'h0;
          next_state = DPA_SETUP;
        end
      end
      DPA_SETUP: begin
        // Selects fall with the strobe, so the memory keeps its outputs off in a write
        if (is_token) begin
          next_sel_n = 1'b1;
          next_tok_n = 1'b0;
          next_hi_n = 1'b1;
          next_lo_n = 1'b1;
        end else begin
          next_sel_n = 1'b0;
          next_tok_n = 1'b1;
          next_hi_n = !lanes[1];
          next_lo_n = !lanes[0];
        end
        if (is_write) begin
          next_wr_n = 1'b0;
          next_oe = 1'b1;
        end else begin
          next_wr_n = 1'b1;
          next_gate_n = 1'b0;
        end
        next_cnt = 4'h0;
        next_state = DPA_STROBE;
      end
      DPA_STROBE: begin
        next_cnt = cnt + 4'h1;
        if (!is_token && !sy.collision_n) begin
          next_state = DPA_WAIT_FREE;
        end else if (cnt == 4'(is_write ? `DPA_WRITE_PULSE_CYC : `DPA_ACCESS_CYC)) begin
          if (!is_write) begin
            next_rdata = is_token ? {15'h0000, sy.data[0]} : sy.data;
          end
          next_wr_n = 1'b1;
          next_gate_n = 1'b1;
          next_cnt = 4'h0;
          next_state = DPA_RELEASE;
        end
      end
      DPA_WAIT_FREE: begin
        // Hold the strobe until the peer leaves, then allow data to settle
        next_cnt = sy.collision_n ? cnt + 4'h1 : 4'h0;
        if (cnt == 4'(`DPA_RELEASE_CYC)) begin
          next_cnt = 4'h0;
          next_state = DPA_STROBE;
        end
      end
      DPA_RELEASE: begin
        next_oe = 1'b0;
        next_sel_n = 1'b1;
        next_tok_n = 1'b1;
        next_hi_n = 1'b1;
        next_lo_n = 1'b1;
        next_cnt = 4'h0;
        next_state = DPA_RECOVER;
      end
      DPA_RECOVER: begin
        // Deselect time covers both the update pulse and the write-to-read gap
        next_cnt = cnt + 4'h1;
        if (cnt >= 4'(`DPA_TOKEN_UPDATE_PULSE_CYC) &&
            cnt >= 4'(`DPA_TOKEN_WRITE_READ_GAP_CYC)) begin
          next_ack = 1'b1;
          next_state = DPA_IDLE;
        end
      end
      default: next_state = DPA_IDLE;
    endcase
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= DPA_IDLE;
      op <= DPA_OP_READ;
      cnt <= 4'h0;
      addr <= 15'h0000;
      wdata <= 16'h0000;
      lanes <= 2'h0;
      sel_n <= 1'b1;
      wr_n <= 1'b1;
      gate_n <= 1'b1;
      hi_n <= 1'b1;
      lo_n <= 1'b1;
      tok_n <= 1'b1;
      oe <= 1'b0;
      ack <= 1'b0;
      rdata <= 16'h0000;
      mbox <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      addr <= next_addr;
      wdata <= next_wdata;
      lanes <= next_lanes;
      sel_n <= next_sel_n;
      wr_n <= next_wr_n;
      gate_n <= next_gate_n;
      hi_n <= next_hi_n;
      lo_n <= next_lo_n;
      tok_n <= next_tok_n;
      oe <= next_oe;
      ack <= next_ack;
      rdata <= next_rdata;
      mbox <= next_mbox;
    end
  end
  // ************************************************************
  // Pin outputs, all straight from flops
  // ************************************************************
  // Token writes place the claim bit on data line 0 (0 claims, 1 frees)
  assign data_o = wdata;
  assign data_oe_o = oe;
  assign addr_o = addr;
  assign select_n_o = sel_n;
  assign write_n_o = wr_n;
  assign gate_n_o = gate_n;
  assign high_lane_select_n_o = hi_n;
  assign low_lane_select_n_o = lo_n;
  assign token_space_select_n_o = tok_n;
  assign ack_o = ack;
  assign rdata_o = rdata;
  assign mailbox_pending_o = mbox;
endmodule
`default_nettype wire

//--- hdl/dpa_pkg.sv
// Types for the two-port memory host controller
package dpa_pkg;
  typedef enum logic [1:0] {DPA_OP_READ, DPA_OP_WRITE, DPA_OP_TOKEN_WRITE, DPA_OP_TOKEN_READ} dpa_op_e;
  typedef enum logic [2:0] {DPA_IDLE, DPA_SETUP, DPA_STROBE, DPA_WAIT_FREE, DPA_RELEASE,
                            DPA_RECOVER} dpa_state_e;
endpackage

//--- hdl/dpa_sync.sv
// Two-flop synchroniser for the memory's asynchronous outputs
`timescale 1ns/1ps
`default_nettype none
`include "dpa_cfg.svh"
module dpa_sync (
  input wire logic mclk_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [15:0] data_pin_i, // Data bus from pins
  input wire logic collision_n_i, // Collision flag pin
  input wire logic mailbox_n_i, // Mailbox flag pin
  dpa_sync_if.src sy // Synchronised outputs
);
  logic [17:0] meta;
  logic [17:0] next_meta;
  logic [17:0] stable;
  logic [17:0] next_stable;
  // Only the second stage is ever read downstream
  always_comb begin
    next_meta = {data_pin_i, collision_n_i, mailbox_n_i};
    next_stable = meta;
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 18'h3FFFF;
      stable <= 18'h3FFFF;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
    end
  end
  assign sy.data = stable[17:2];
  assign sy.collision_n = stable[1];
  assign sy.mailbox_n = stable[0];
endmodule
`default_nettype wire

//--- hdl/dpa_sync_if.sv
// Interface carrying synchronised pin inputs to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface dpa_sync_if;
  logic [15:0] data;
  logic collision_n;
  logic mailbox_n;
  modport src (output data, output collision_n, output mailbox_n);
  modport dst (input data, input collision_n, input mailbox_n);
endinterface
`default_nettype wire

//--- tb/dpa_host_checker.sv
// Pin sequencing checks for the memory host
`timescale 1ns/1ps
`default_nettype none
module dpa_host_checker (
  input wire logic mclk_i, // Clock
  input wire logic rstn_i, // Reset, active low
  input wire logic [14:0] addr_o, // Address pins
  input wire logic select_n_o, // Port select
  input wire logic write_n_o, // Write strobe
  input wire logic gate_n_o, // Output gate
  input wire logic high_lane_select_n_o, // Upper lane
  input wire logic low_lane_select_n_o, // Lower lane
  input wire logic token_space_select_n_o, // Token select
  input wire logic data_oe_o // Host drives data
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // A token write ends while the token select is still low
  sequence tok_wr_end;
    $rose(write_n_o) && !token_space_select_n_o;
  endsequence
  array_sel_a: assert property (!select_n_o |-> token_space_select_n_o &&
    !(high_lane_select_n_o && low_lane_select_n_o)) else $error("bad array select");
  token_sel_a: assert property (!token_space_select_n_o |-> select_n_o)
    else $error("bad token select");
  read_strobe_a: assert property (!gate_n_o |-> write_n_o) else $error("strobe in read");
  addr_move_a: assert property ($changed(addr_o) |-> write_n_o && $past(write_n_o))
    else $error("address moved in write");
  write_overlap_a: assert property (!write_n_o |-> data_oe_o &&
    (!select_n_o || !token_space_select_n_o)) else $error("bad write overlap");
  bus_fight_a: assert property (data_oe_o |-> gate_n_o) else $error("bus fight");
  write_start_a: assert property ($fell(write_n_o) |->
    $fell(select_n_o) || $fell(token_space_select_n_o)) else $error("select after strobe");
  token_strobe_a: assert property ($rose(gate_n_o) && !token_space_select_n_o
    |-> ##[0:2] token_space_select_n_o) else $error("token read not strobed");
  token_pulse_a: assert property ($rose(token_space_select_n_o) |=> token_space_select_n_o)
    else $error("token pulse short");
  token_gap_a: assert property (tok_wr_end |=> gate_n_o) else $error("no gap after token write");
endmodule
bind dpa_host dpa_host_checker u_chk (.mclk_i, .rstn_i, .addr_o, .select_n_o, .write_n_o,
  .gate_n_o, .high_lane_select_n_o, .low_lane_select_n_o, .token_space_select_n_o, .data_oe_o);
`default_nettype wire

//--- tb/dpa_mem_model.sv
// Behavioural model of one port of the two-port memory
`timescale 1ns/1ps
`default_nettype none
`include "dpa_cfg.svh"
module dpa_mem_model (
  input wire logic [14:0] addr_i, // Address pins
  input wire logic sel_n_i, // Port select
  input wire logic wr_n_i, // Write strobe
  input wire logic oe_n_i, // Output gate
  input wire logic [1:0] lane_n_i, // Upper, lower lane
  input wire logic tok_n_i, // Token select
  input wire logic [15:0] hd_i, // Host data
  input wire logic hoe_i, // Host drives data
  input wire logic [14:0] peer_addr_i, // Other port location
  input wire logic peer_on_i, // Other port busy there
  input wire logic mbx_set_i, // Other port posts mail
  output logic [15:0] bus_o, // Resolved data bus
  output logic coll_n_o, // Collision flag
  output logic mbx_n_o // Mailbox flag
);
  logic [15:0] mem [0:32767];
  logic [7:0] tok = 8'hFF;
  logic [15:0] drv;
  logic mbx = 1'b0;
  logic rd;
  wire logic arr = !sel_n_i && tok_n_i && (lane_n_i != 2'h3);
  wire logic tsp = sel_n_i && !tok_n_i;
  wire logic rd_own = arr && !oe_n_i && wr_n_i && (addr_i == `DPA_MAILBOX_OWN);
  // Unwritten words read back as a fixed pattern, never as unknowns
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'hC3C3;
  end
  // Commit at the end of the strobe overlap
  always @(posedge wr_n_i) begin
    if (arr) begin
      if (!lane_n_i[1]) mem[addr_i][15:8] = hd_i[15:8];
      if (!lane_n_i[0]) mem[addr_i][7:0] = hd_i[7:0];
    end
    if (tsp) tok[addr_i[2:0]] = hd_i[0];
  end
  // Mail arrives from the far port; our read of the own slot clears it
  // Clear keys on the settled read condition, so select and gate order cannot race
  always @(posedge mbx_set_i or posedge rd_own) begin
    if (mbx_set_i) mbx = 1'b1;
    else mbx = 1'b0;
  end
  assign mbx_n_o = !mbx;
  assign coll_n_o = !(peer_on_i && arr && addr_i == peer_addr_i);
  // Undriven lanes show the inverse so stale data never passes
  always @* begin
    drv = tsp ? {16{tok[addr_i[2:0]]}} : mem[addr_i];
    rd = (arr || tsp) && !oe_n_i && wr_n_i && coll_n_o;
    for (int i = 0; i < 2; i++) begin
      bus_o[i*8 +: 8] = hoe_i ? hd_i[i*8 +: 8] :
        ((rd && (tsp || !lane_n_i[i])) ? drv[i*8 +: 8] : ~drv[i*8 +: 8]);
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_dpa_host.sv
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
`default_nettype none
`include "dpa_cfg.svh"
module tb_dpa_host;
  logic mclk_i = 1'b0, rstn_i = 1'b0, req_i = 1'b0, peer_on = 1'b0, mbx_set = 1'b0;
  logic ack_o, mbp, selo, wro, oeo, hlo, llo, tko, doe, coll_n, mbx_n;
  logic [1:0] op_i = 2'h0, lanes_i = 2'h3;
  logic [14:0] addr_i = 15'h0000, peer_addr = 15'h0000, addr_o;
  logic [15:0] wdata_i = 16'h0000, rdata_o, dout, bus;
  int error_cnt = 0, n_tests = 0;
  initial forever #25 mclk_i = ~mclk_i;
  dpa_host u_dut (.mclk_i, .rstn_i, .req_i, .op_i, .addr_i, .wdata_i, .lanes_i, .ack_o,
    .rdata_o, .mailbox_pending_o(mbp), .addr_o, .select_n_o(selo), .write_n_o(wro),
    .gate_n_o(oeo), .high_lane_select_n_o(hlo), .low_lane_select_n_o(llo),
    .token_space_select_n_o(tko), .data_i(bus), .data_o(dout), .data_oe_o(doe),
    .collision_n_i(coll_n), .mailbox_n_i(mbx_n));
  dpa_mem_model u_mem (.addr_i(addr_o), .sel_n_i(selo), .wr_n_i(wro), .oe_n_i(oeo),
    .lane_n_i({hlo, llo}), .tok_n_i(tko), .hd_i(dout), .hoe_i(doe), .peer_addr_i(peer_addr),
    .peer_on_i(peer_on), .mbx_set_i(mbx_set), .bus_o(bus), .coll_n_o(coll_n), .mbx_n_o(mbx_n));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  // One request, then a bounded wait for the done pulse
  task automatic xfer(input logic [1:0] o, input logic [14:0] a, input logic [15:0] d,
                      input logic [1:0] l);
    int n;
    @(posedge mclk_i);
    op_i <= o;
    addr_i <= a;
    wdata_i <= d;
    lanes_i <= l;
    req_i <= 1'b1;
    @(posedge mclk_i);
    req_i <= 1'b0;
    for (n = 0; n < 200 && ack_o !== 1'b1; n++) @(negedge mclk_i);
    chk("ack", {15'h0000, ack_o}, 16'h0001);
  endtask
  task automatic t_lanes;
    xfer(2'h1, 15'h0005, 16'h1234, 2'h3);
    xfer(2'h1, 15'h0005, 16'hABCD, 2'h2);
    xfer(2'h0, 15'h0005, 16'h0000, 2'h3);
    chk("upper write", rdata_o, 16'hAB34);
    xfer(2'h0, 15'h0005, 16'h0000, 2'h1);
    chk("lower read", {8'h00, rdata_o[7:0]}, 16'h0034);
  endtask
  task automatic t_token;
    xfer(2'h2, 15'h0003, 16'h0000, 2'h3);
    xfer(2'h3, 15'h0003, 16'h0000, 2'h3);
    chk("token taken", {15'h0000, rdata_o[0]}, 16'h0000);
    xfer(2'h2, 15'h0003, 16'h0001, 2'h3);
    xfer(2'h3, 15'h0003, 16'h0000, 2'h3);
    chk("token freed", {15'h0000, rdata_o[0]}, 16'h0001);
  endtask
  task automatic t_mail;
    @(posedge mclk_i);
    mbx_set <= 1'b1;
    @(posedge mclk_i);
    mbx_set <= 1'b0;
    repeat (4) @(negedge mclk_i);
    chk("mail set", {15'h0000, mbp}, 16'h0001);
    xfer(2'h0, `DPA_MAILBOX_OWN, 16'h0000, 2'h3);
    repeat (4) @(negedge mclk_i);
    chk("mail clear", {15'h0000, mbp}, 16'h0000);
  endtask
  // Far port holds the location: the host must wait, then read good data
  task automatic t_collide;
    xfer(2'h1, 15'h0009, 16'h5A5A, 2'h3);
    @(posedge mclk_i);
    peer_addr <= 15'h0009;
    peer_on <= 1'b1;
    fork
      xfer(2'h0, 15'h0009, 16'h0000, 2'h3);
      begin
        repeat (20) @(negedge mclk_i);
        chk("held", {15'h0000, selo}, 16'h0000);
        @(posedge mclk_i);
        peer_on <= 1'b0;
      end
    join
    chk("after wait", rdata_o, 16'h5A5A);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    chk("reset pins", {13'h0000, selo, wro, tko}, 16'h0007);
    rstn_i <= 1'b1;
    t_lanes;
    t_token;
    t_mail;
    t_collide;
    report_and_stop;
  end
endmodule
`default_nettype wire
